// file: core/asu_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  asynchronous serial unit.
  Assumes inclusion by bare name from the unit's module and the bench.
*/
// Behaviour
// R1: Frame is start low, data LSB first, optional parity or flag, stop high.
// R2: Idle line rests high; a drop to low marks a character start.
// R3: Receiver syncs on start edge, samples at 16x, latches on eighth pulse.
// R4: Transmitter and receiver are independent, each holding plus shift reg.
// R5: Mode bits select length, address-flag format, parity and stop length.
// R6: Send parity when enabled, flag bit in flag format, else neither.
// R7: All bit timing comes from the internal baud rate generator only.
// R8: Clearing transmit enable forces buffer empty and resets the shifter.
// R9: Clearing receive enable keeps receive flags and holding register.
// R10: Software clears both enables before changing mode or format.
// R11: Software sets control, format, rate, waits a bit, then enables.
// R12: Enabling takes the pin; transmitter marks, receiver waits for start.
// R13: Empty flag at zero means new data; move holding into shifter.
// R14: After the move set empty flag, start shifting, request empty irq.
// R15: Pin sends one 0 start, 7 or 8 data bits, then 1 or 2 stops.
// R16: Between frames the transmitter keeps driving 1.
// R17: At stop bit, empty flag zero loads next frame right after stops.
// R18: At stop bit with buffer empty set done flag, mark, request done irq.
// R19: Receiver stays stopped while overrun, parity or framing flag is set.
// R20: Receive pin level is readable by software for break detection.
// R21: Receive-full irq is raised when the full flag goes from 0 to 1.
// R22: Software reads data and clears full flag before next stop bit.
// R23: Overrun drops the new character; framing or parity error keeps it.
// R24: With two stop bits only the first is checked for framing.
// R25: Received parity is checked against the parity-sense selection.
// R26: Any receive error flag with receive irq enable requests error irq.
// R27: Start bit high at mid-bit returns receiver to idle, no error.
// R28: Parity covers the 7 or 8 data bits only.
`ifndef ASU_REGS_SVH
`define ASU_REGS_SVH
// ==========================================================================
// Offsets
`define ASU_MODE_OFS     3'h0
`define ASU_CTRL_OFS     3'h1
`define ASU_FLAG_OFS     3'h2
`define ASU_RATE_OFS     3'h3
`define ASU_TXD_OFS      3'h4
`define ASU_RXD_OFS      3'h5
`define ASU_LINE_OFS     3'h6
// ==========================================================================
// Control bits
`define ASU_TXIE_BIT     7
`define ASU_RXIE_BIT     6
`define ASU_TXEN_BIT     5
`define ASU_RXEN_BIT     4
`define ASU_IDW_BIT      3
`define ASU_TDIE_BIT     2
// ==========================================================================
// Flag bits
`define ASU_TXE_BIT      7
`define ASU_RXF_BIT      6
`define ASU_OVR_BIT      5
`define ASU_FRM_BIT      4
`define ASU_PAR_BIT      3
`define ASU_TXD_BIT      2
`define ASU_AFR_BIT      1
`define ASU_AFT_BIT      0
// ==========================================================================
// Reset values and timing
`define ASU_MODE_RST     8'h00
`define ASU_CTRL_RST     8'h00
`define ASU_RATE_RST     8'hFF
`define ASU_SUB_MID      4'h7
`define ASU_SUB_LAST     4'hF
`define ASU_LAST7        3'h6
`define ASU_LAST8        3'h7
`endif

// file: core/asu_pkg.sv
/*
  Types of the asynchronous serial unit: frame mode carrier and states.
  Assumes the register header is on the include path.
*/
package asu_pkg;
  // ========================================================================
  // Mode carrier, laid out as the mode register bits 6..2
  typedef struct packed {
    logic charLen7;
    logic parityOn;
    logic parityOdd;
    logic stopTwo;
    logic addrFormat;
  } asu_mode_s;
  // ========================================================================
  // Line states shared by both directions
  typedef enum logic [2:0] {
    LN_IDLE  = 3'b000,
    LN_START = 3'b001,
    LN_DATA  = 3'b010,
    LN_PAR   = 3'b011,
    LN_STOP  = 3'b100
  } asu_line_e;
endpackage

// file: core/asu_serial_unit.sv
/*
  Asynchronous serial transmitter and receiver with mode, control, flag,
  bit-rate and data registers behind a plain strobe port.
  Assumes a synchronous rx pin and a master that never overlaps strobes.
*/
`timescale 1ns/1ps
`include "asu_regs.svh"
module asu_serial_unit
  import asu_pkg::*;
#(
  parameter int DW = 8                 // Character width
) (
  input  wire logic          clk,      // 25 MHz clock
  input  wire logic          sys_rst,  // Async reset, active high
  input  wire logic [2:0]    regAddr,  // Register offset
  input  wire logic [DW-1:0] regWdata, // Write data
  input  wire logic          regWr,    // Write strobe
  input  wire logic          regRd,    // Read strobe
  output logic      [DW-1:0] regRdata, // Read data, cycle after strobe
  input  wire logic          rxIn,     // Receive pin
  output logic               txOut,    // Transmit pin level
  output logic               txOe_n,   // Low while driving transmit pin
  output logic               txEmptyIrq, // Transmit-empty request
  output logic               txDoneIrq,  // Transmit-done request
  output logic               rxFullIrq,  // Receive-full request
  output logic               rxErrIrq    // Receive-error request
);
  // ========================================================================
  // Registers
  logic [DW-1:0] modeReg, ctrlReg, rateReg, txHoldReg, rxHoldReg;
  logic          txEmpty, txDone, rxFull, ovrFlag, frmFlag, parFlag;
  logic          addrFlagRx, addrFlagTx;
  asu_mode_s     mode;
  logic          txEn, rxEn;
  logic          wrMode, wrCtrl, wrFlag, wrRate, wrTxd;

  assign mode   = asu_mode_s'(modeReg[6:2]);
  assign txEn   = ctrlReg[`ASU_TXEN_BIT];
  assign rxEn   = ctrlReg[`ASU_RXEN_BIT];
  assign wrMode = regWr && (regAddr == `ASU_MODE_OFS);
  assign wrCtrl = regWr && (regAddr == `ASU_CTRL_OFS);
  assign wrFlag = regWr && (regAddr == `ASU_FLAG_OFS);
  assign wrRate = regWr && (regAddr == `ASU_RATE_OFS);
  assign wrTxd  = regWr && (regAddr == `ASU_TXD_OFS);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeReg   <= `ASU_MODE_RST;
      ctrlReg   <= `ASU_CTRL_RST;
      rateReg   <= `ASU_RATE_RST;
      txHoldReg <= '0;
    end else begin
      if (wrMode) begin
        modeReg <= regWdata; // R5
      end
      if (wrCtrl) begin
        ctrlReg <= regWdata;
      end
      if (wrRate) begin
        rateReg <= regWdata;
      end
      if (wrTxd) begin
        txHoldReg <= regWdata;
      end
    end
  end

  // ========================================================================
  // Baud generator: one pulse per sixteenth of a bit
  logic [DW-1:0] baudCnt;
  logic          tick16;

  assign tick16 = (baudCnt == rateReg); // R7
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      baudCnt <= '0;
    end else if (tick16 || wrRate) begin
      baudCnt <= '0;
    end else begin
      baudCnt <= baudCnt + 1'b1;
    end
  end

  // ========================================================================
  // Transmitter
  asu_line_e     txState;
  logic [3:0]    txSub;
  logic [2:0]    txBit;
  logic          txStop2, txPend, txParBit;
  logic [DW-1:0] txShift, txData;
  logic [2:0]    lastBit;
  logic          txBitEnd, txToStop, txLoadIdle, txLoadStop, txLoad;
  logic          txDoneSet, txLine;

  assign lastBit  = mode.charLen7 ? `ASU_LAST7 : `ASU_LAST8;
  assign txData   = mode.charLen7 ? {1'b0, txHoldReg[DW-2:0]} : txHoldReg;
  assign txBitEnd = tick16 && (txSub == `ASU_SUB_LAST);
  assign txToStop = txBitEnd && ((txState == LN_PAR) ||
                    (txState == LN_DATA && txBit == lastBit &&
                     !mode.addrFormat && !mode.parityOn));
  assign txLoadIdle = txEn && (txState == LN_IDLE) && !txEmpty; // R13
  assign txLoadStop = txEn && txToStop && !txEmpty; // R17
  assign txLoad     = txLoadIdle || txLoadStop;
  assign txDoneSet  = txEn && txToStop && txEmpty; // R18

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txState  <= LN_IDLE;
      txSub    <= '0;
      txBit    <= '0;
      txStop2  <= 1'b0;
      txPend   <= 1'b0;
      txParBit <= 1'b0;
      txShift  <= '0;
    end else if (!txEn) begin
      txState <= LN_IDLE; // R8
      txShift <= '0;
      txPend  <= 1'b0;
      txSub   <= '0;
    end else begin
      if (tick16) begin
        txSub <= txSub + 1'b1;
      end
      case (txState)
        LN_IDLE: begin
          if (txLoadIdle) begin
            txState <= LN_START; // R14
            txSub   <= '0;
          end
        end
        LN_START: begin
          if (txBitEnd) begin
            txState <= LN_DATA;
            txBit   <= '0;
          end
        end
        LN_DATA: begin
          if (txBitEnd) begin
            txShift <= txShift >> 1; // R1
            txBit   <= txBit + 1'b1;
            if (txBit == lastBit) begin
              txStop2 <= 1'b0;
              txState <= (mode.addrFormat || mode.parityOn) ? LN_PAR
                                                            : LN_STOP;
            end
          end
        end
        LN_PAR: begin
          if (txBitEnd) begin
            txState <= LN_STOP;
            txStop2 <= 1'b0;
          end
        end
        LN_STOP: begin
          if (txBitEnd) begin
            if (mode.stopTwo && !txStop2) begin
              txStop2 <= 1'b1;
            end else begin
              txState <= txPend ? LN_START : LN_IDLE; // R17
              txPend  <= 1'b0;
            end
          end
        end
        default: begin
          txState <= LN_IDLE;
        end
      endcase
      if (txLoad) begin
        txShift  <= txData;
        txPend   <= txLoadStop;
        // Flag format ignores parity enable; odd sense inverts even parity
        txParBit <= mode.addrFormat ? addrFlagTx
                                    : (^txData) ^ mode.parityOdd; // R6 R28
      end
    end
  end

  always_comb begin
    case (txState)
      LN_START: txLine = 1'b0; // R15
      LN_DATA:  txLine = txShift[0];
      LN_PAR:   txLine = txParBit; // R6
      default:  txLine = 1'b1; // R16
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txOut  <= 1'b1;
      txOe_n <= 1'b1;
    end else begin
      txOut  <= txLine; // R2
      txOe_n <= !txEn; // R12
    end
  end

  // ========================================================================
  // Receiver
  asu_line_e     rxState;
  logic [3:0]    rxSub;
  logic [2:0]    rxBit;
  logic [DW-1:0] rxShift, rxData;
  logic          rxPrev, rxParBit, rxSample, rxEnd, rxStore, rxParErr, rxBlock;

  assign rxBlock  = ovrFlag || frmFlag || parFlag;
  assign rxSample = tick16 && (rxSub == `ASU_SUB_MID); // R3
  // Gated so a frame cut by a disable cannot touch the flags
  assign rxEnd    = rxEn && (rxState == LN_STOP) && rxSample; // R9
  assign rxStore  = rxEnd && !rxFull; // R23
  // Seven-bit characters land in the top bits after the last shift
  assign rxData   = mode.charLen7 ? {1'b0, rxShift[DW-1:1]} : rxShift;
  assign rxParErr = mode.parityOn && !mode.addrFormat &&
                    (((^rxData) ^ mode.parityOdd) != rxParBit); // R25 R28

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxPrev <= 1'b1;
    end else begin
      rxPrev <= rxIn;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxState  <= LN_IDLE;
      rxSub    <= '0;
      rxBit    <= '0;
      rxShift  <= '0;
      rxParBit <= 1'b0;
    end else if (!rxEn) begin
      rxState <= LN_IDLE; // R9
    end else begin
      if (tick16) begin
        rxSub <= rxSub + 1'b1;
      end
      case (rxState)
        LN_IDLE: begin
          // A held error flag keeps the receiver parked
          if (!rxBlock && rxPrev && !rxIn) begin
            rxState <= LN_START; // R2 R3 R19
            rxSub   <= '0;
          end
        end
        LN_START: begin
          if (rxSample) begin
            rxState <= rxIn ? LN_IDLE : LN_DATA; // R27
            rxBit   <= '0;
          end
        end
        LN_DATA: begin
          if (rxSample) begin
            rxShift <= {rxIn, rxShift[DW-1:1]}; // R1
            rxBit   <= rxBit + 1'b1;
            if (rxBit == lastBit) begin
              rxState <= (mode.addrFormat || mode.parityOn) ? LN_PAR
                                                            : LN_STOP;
            end
          end
        end
        LN_PAR: begin
          if (rxSample) begin
            rxParBit <= rxIn;
            rxState  <= LN_STOP;
          end
        end
        LN_STOP: begin
          // Only the first stop is looked at; a second one reads as idle
          if (rxSample) begin
            rxState <= LN_IDLE; // R24
          end
        end
        default: begin
          rxState <= LN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxHoldReg  <= '0;
      addrFlagRx <= 1'b0;
    end else if (rxStore) begin
      rxHoldReg  <= rxData; // R4 R23
      addrFlagRx <= mode.addrFormat && rxParBit;
    end
  end

  // ========================================================================
  // Flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txEmpty    <= 1'b1;
      txDone     <= 1'b1;
      rxFull     <= 1'b0;
      ovrFlag    <= 1'b0;
      frmFlag    <= 1'b0;
      parFlag    <= 1'b0;
      addrFlagTx <= 1'b0;
    end else begin
      if (!txEn || txLoad) begin
        txEmpty <= 1'b1; // R8 R14
      end else if (wrFlag && !regWdata[`ASU_TXE_BIT]) begin
        txEmpty <= 1'b0;
      end
      if (txDoneSet) begin
        txDone <= 1'b1; // R18
      end else if (txLoad || (wrFlag && !regWdata[`ASU_TXD_BIT])) begin
        txDone <= 1'b0;
      end
      if (rxStore) begin
        rxFull <= 1'b1;
      end else if (wrFlag && !regWdata[`ASU_RXF_BIT]) begin
        rxFull <= 1'b0;
      end
      if (rxEnd && rxFull) begin
        ovrFlag <= 1'b1; // R23
      end else if (wrFlag && !regWdata[`ASU_OVR_BIT]) begin
        ovrFlag <= 1'b0;
      end
      if (rxEnd && !rxIn) begin
        frmFlag <= 1'b1; // R24
      end else if (wrFlag && !regWdata[`ASU_FRM_BIT]) begin
        frmFlag <= 1'b0;
      end
      if (rxEnd && rxParErr) begin
        parFlag <= 1'b1; // R25
      end else if (wrFlag && !regWdata[`ASU_PAR_BIT]) begin
        parFlag <= 1'b0;
      end
      if (wrFlag) begin
        addrFlagTx <= regWdata[`ASU_AFT_BIT];
      end
    end
  end

  assign txEmptyIrq = ctrlReg[`ASU_TXIE_BIT] && txEmpty; // R14
  assign txDoneIrq  = ctrlReg[`ASU_TDIE_BIT] && txDone; // R18
  assign rxFullIrq  = ctrlReg[`ASU_RXIE_BIT] && rxFull; // R21
  assign rxErrIrq   = ctrlReg[`ASU_RXIE_BIT] && rxBlock; // R26

  // ========================================================================
  // Read port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        `ASU_MODE_OFS: regRdata <= modeReg;
        `ASU_CTRL_OFS: regRdata <= ctrlReg;
        `ASU_FLAG_OFS: regRdata <= {txEmpty, rxFull, ovrFlag, frmFlag,
                                    parFlag, txDone, addrFlagRx, addrFlagTx};
        `ASU_RATE_OFS: regRdata <= rateReg;
        `ASU_TXD_OFS:  regRdata <= txHoldReg;
        `ASU_RXD_OFS:  regRdata <= rxHoldReg;
        `ASU_LINE_OFS: regRdata <= {{(DW-1){1'b0}}, rxIn}; // R20
        default:       regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_tx_off_empty: assert property ( // R8
    !txEn |=> txEmpty && txState == LN_IDLE)
    else $error("transmit disable left buffer full");
  chk_load_empty: assert property ( // R14
    txLoad |=> txEmpty && txShift == $past(txData))
    else $error("load did not set empty flag");
  chk_idle_marks: assert property (txEn && txState == LN_IDLE |=> txOut) // R16
    else $error("idle line not marking");
  chk_start_low: assert property (txState == LN_START |=> !txOut) // R15
    else $error("start bit not low");
  chk_done_set: assert property ( // R18
    txDoneSet |=> txDone && txState == LN_STOP)
    else $error("done flag not set at stop");
  chk_rx_blocked: assert property ( // R19
    rxBlock && rxState == LN_IDLE |=> rxState == LN_IDLE)
    else $error("receiver resumed with error flag");
  chk_ovr_drop: assert property ( // R23
    rxEnd && rxFull |=> $stable(rxHoldReg) && ovrFlag)
    else $error("overrun character stored");
  chk_frame_flag: assert property (rxEnd && !rxIn |=> frmFlag) // R24
    else $error("framing error missed");
  chk_false_start: assert property ( // R27
    rxState == LN_START && rxSample && rxIn |=>
      rxState == LN_IDLE && !rxBlock)
    else $error("false start not dropped");
  chk_full_irq: assert property ( // R21
    rxStore && ctrlReg[`ASU_RXIE_BIT] && !wrCtrl |=> rxFullIrq)
    else $error("receive-full request missing");
  // Software may still clear flags while the receiver is off
  chk_rx_off_keep: assert property ( // R9
    !rxEn && !wrFlag |=> $stable(rxHoldReg) && $stable(rxFull))
    else $error("receive disable changed state");
  cov_back_to_back: cover property (txLoadStop);
  cov_rx_store: cover property (rxStore && !rxParErr);
  cov_overrun: cover property (rxEnd && rxFull);
  cov_two_stop: cover property (txState == LN_STOP && txStop2 && txBitEnd);
endmodule

// file: dv/asu_far_end.sv
/*
  Behavioural far-end serial device: frames characters onto the unit's
  receive pin and decodes the frames that the unit transmits.
  Assumes the bench clock and a bit period of BITC clocks.
*/
`timescale 1ns/1ps
module asu_far_end #(
  parameter int BITC = 16     // Clocks per bit
) (
  input  wire logic clk,      // Bench clock
  input  wire logic txLine,   // Unit transmit pin
  output logic      rxLine    // Unit receive pin
);
  int         nBits = 8;      // Bits after start that the decoder takes
  int         cyc   = 0;
  int         t0;
  logic [8:0] w;
  logic [8:0] wordQ[$];
  logic       stopQ[$];
  int         startQ[$];

  initial rxLine = 1'b1;
  always @(posedge clk) cyc <= cyc + 1;

  // ========================================================================
  // Decoder: samples at bit centres, as a real far end does
  always begin
    @(posedge clk);
    if (txLine === 1'b0) begin
      t0 = cyc;
      repeat (BITC/2) @(posedge clk);
      if (txLine === 1'b0) begin
        w = 9'h000;
        for (int i = 0; i < nBits; i++) begin
          repeat (BITC) @(posedge clk);
          w[i] = txLine;
        end
        repeat (BITC) @(posedge clk);
        stopQ.push_back(txLine);
        wordQ.push_back(w);
        startQ.push_back(t0);
      end
    end
  end

  // ========================================================================
  // Sender
  task automatic drive(input logic v, input int c);
    rxLine <= v;
    repeat (c) @(posedge clk);
  endtask

  task automatic send(input logic [8:0] d, input int n,
                      input logic [1:0] st, input int ns);
    @(posedge clk);
    drive(1'b0, BITC);
    for (int i = 0; i < n; i++) drive(d[i], BITC);
    for (int i = 0; i < ns; i++) drive(st[i], BITC);
    drive(1'b1, BITC);
  endtask
endmodule

// file: dv/testbench.sv
/*
  Self-checking bench of the asynchronous serial unit.
  Assumes the far-end model and the register header are available.
*/
`timescale 1ns/1ps
`include "asu_regs.svh"
module testbench;
  import asu_pkg::*;
  logic       clk        = 1'b0;
  logic       sys_rst    = 1'b1;
  logic [2:0] regAddr    = 3'h0;
  logic [7:0] regWdata   = 8'h00;
  logic       regWr      = 1'b0;
  logic       regRd      = 1'b0;
  logic [7:0] regRdata;
  logic       rxIn;
  logic       txOut;
  logic       txOe_n;
  logic       txEmptyIrq;
  logic       txDoneIrq;
  logic       rxFullIrq;
  logic       rxErrIrq;
  logic [7:0] rv;
  int         bad_count  = 0;
  int         num_checks = 0;

  asu_serial_unit #(.DW(8)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxIn(rxIn),
    .txOut(txOut), .txOe_n(txOe_n), .txEmptyIrq(txEmptyIrq),
    .txDoneIrq(txDoneIrq), .rxFullIrq(rxFullIrq), .rxErrIrq(rxErrIrq));
  asu_far_end #(.BITC(16)) far_u (.clk(clk), .txLine(txOut), .rxLine(rxIn));

  always #20 clk = ~clk;

  // ========================================================================
  // Common tasks
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic rflags(input string nm, input logic [7:0] e);
    repeat (4) @(posedge clk);
    rd(`ASU_FLAG_OFS, rv);
    chk(nm, 9'(e), 9'(rv & 8'h78));
  endtask

  task automatic waitq(input int n);
    int k;
    k = 0;
    while (far_u.wordQ.size() < n && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (far_u.wordQ.size() < n) begin
      chk("frame wait", 9'h000, 9'h1FF);
      stop_test();
    end
  endtask

  // Software must drop both enables before touching the format
  task automatic cfg(input logic [7:0] m, input logic [7:0] c);
    wr(`ASU_CTRL_OFS, 8'h00);
    wr(`ASU_MODE_OFS, m);
    wr(`ASU_RATE_OFS, 8'h00);
    repeat (16) @(posedge clk);
    wr(`ASU_CTRL_OFS, c);
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_reset();
    chk("txOut idle", 9'h001, 9'(txOut));
    chk("txOe_n off", 9'h001, 9'(txOe_n));
    rd(`ASU_MODE_OFS, rv);
    chk("mode", 9'(`ASU_MODE_RST), 9'(rv));
    rd(`ASU_CTRL_OFS, rv);
    chk("ctrl", 9'(`ASU_CTRL_RST), 9'(rv));
    rd(`ASU_RATE_OFS, rv);
    chk("rate", 9'(`ASU_RATE_RST), 9'(rv));
    rd(`ASU_FLAG_OFS, rv);
    chk("flags", 9'h084, 9'(rv));
    wr(3'h7, 8'hFF);
    rd(3'h7, rv);
    chk("unmapped", 9'h000, 9'(rv));
    rd(`ASU_LINE_OFS, rv);
    chk("line idle", 9'h001, 9'(rv[0]));
  endtask

  task automatic t_tx();
    logic [7:0] md[6] = '{8'h00, 8'h68, 8'h30, 8'h44, 8'h2C, 8'h58};
    logic [7:0] dt[6] = '{8'hA5, 8'hD3, 8'h0F, 8'hE1, 8'h96, 8'hFE};
    logic [8:0] e;
    logic       n7;
    logic       ex;
    logic       fb;
    for (int i = 0; i < 6; i++) begin
      n7 = md[i][6];
      ex = md[i][5] | md[i][2];
      fb = i[0];
      far_u.nBits = (n7 ? 7 : 8) + (ex ? 1 : 0);
      e = n7 ? {2'b00, dt[i][6:0]} : {1'b0, dt[i]};
      if (ex) e[n7 ? 7 : 8] = md[i][2] ? fb : (^e ^ md[i][4]);
      cfg(md[i], 8'hA4);
      repeat (2) @(posedge clk);
      chk("txOe_n on", 9'h000, 9'(txOe_n));
      wr(`ASU_TXD_OFS, dt[i]);
      wr(`ASU_FLAG_OFS, {7'h3F, fb});
      repeat (6) @(posedge clk);
      chk("start bit", 9'h000, 9'(txOut));
      chk("empty irq", 9'h001, 9'(txEmptyIrq));
      chk("done irq low", 9'h000, 9'(txDoneIrq));
      waitq(1);
      chk("tx word", e, far_u.wordQ.pop_front());
      chk("tx stop", 9'h001, 9'(far_u.stopQ.pop_front()));
      repeat (36) @(posedge clk);
      chk("done irq", 9'h001, 9'(txDoneIrq));
      chk("marking", 9'h001, 9'(txOut));
      far_u.startQ.delete();
    end
  endtask

  task automatic t_b2b();
    cfg(8'h00, 8'h20);
    far_u.nBits = 8;
    wr(`ASU_TXD_OFS, 8'h3C);
    wr(`ASU_FLAG_OFS, 8'h7E);
    repeat (20) @(posedge clk);
    wr(`ASU_TXD_OFS, 8'hC3);
    wr(`ASU_FLAG_OFS, 8'h7E);
    waitq(2);
    chk("first", 9'h03C, far_u.wordQ.pop_front());
    chk("second", 9'h0C3, far_u.wordQ.pop_front());
    chk("no gap", 9'd160, 9'(far_u.startQ[1] - far_u.startQ[0]));
    far_u.startQ.delete();
    far_u.stopQ.delete();
  endtask

  task automatic t_abort();
    wr(`ASU_TXD_OFS, 8'h00);
    wr(`ASU_FLAG_OFS, 8'h7E);
    repeat (20) @(posedge clk);
    wr(`ASU_FLAG_OFS, 8'h7E);
    repeat (40) @(posedge clk);
    wr(`ASU_CTRL_OFS, 8'h00);
    repeat (3) @(posedge clk);
    chk("abort line", 9'h001, 9'(txOut));
    rd(`ASU_FLAG_OFS, rv);
    chk("abort empty", 9'h001, 9'(rv[7]));
    repeat (400) @(posedge clk);
    chk("no restart", 9'h001, 9'(far_u.startQ.size()));
    far_u.startQ.delete();
    far_u.stopQ.delete();
    far_u.wordQ.delete();
  endtask

  task automatic t_rx();
    cfg(8'h20, 8'h70);
    far_u.nBits = 9;
    far_u.drive(1'b0, 4);
    far_u.drive(1'b1, 40);
    rflags("glitch", 8'h00);
    wr(`ASU_TXD_OFS, 8'h69);
    wr(`ASU_FLAG_OFS, 8'h7E);
    far_u.send({^8'h96, 8'h96}, 9, 2'b11, 1);
    rflags("rx good", 8'h40);
    chk("full irq", 9'h001, 9'(rxFullIrq));
    chk("err irq low", 9'h000, 9'(rxErrIrq));
    rd(`ASU_RXD_OFS, rv);
    chk("rx data", 9'h096, 9'(rv));
    wr(`ASU_FLAG_OFS, 8'hBF);
    waitq(1);
    chk("duplex tx", {^8'h69, 8'h69}, far_u.wordQ.pop_front());
    far_u.send({~^8'h5A, 8'h5A}, 9, 2'b11, 1);
    rflags("parity", 8'h48);
    chk("err irq", 9'h001, 9'(rxErrIrq));
    rd(`ASU_RXD_OFS, rv);
    chk("parity data", 9'h05A, 9'(rv));
    wr(`ASU_FLAG_OFS, 8'h84);
  endtask

  task automatic t_err();
    far_u.send({^8'h33, 8'h33}, 9, 2'b00, 1);
    rflags("framing", 8'h50);
    rd(`ASU_RXD_OFS, rv);
    chk("framing data", 9'h033, 9'(rv));
    wr(`ASU_FLAG_OFS, 8'hBF);
    far_u.drive(1'b0, 1);
    rd(`ASU_LINE_OFS, rv);
    chk("line break", 9'h000, 9'(rv[0]));
    far_u.drive(1'b1, 16);
    far_u.send({^8'h11, 8'h11}, 9, 2'b11, 1);
    rflags("blocked", 8'h10);
    wr(`ASU_FLAG_OFS, 8'h84);
    far_u.send({^8'h22, 8'h22}, 9, 2'b11, 1);
    rflags("resumed", 8'h40);
    wr(`ASU_FLAG_OFS, 8'h84);
  endtask

  task automatic t_stops();
    cfg(8'h08, 8'h50);
    far_u.send({1'b0, 8'h81}, 8, 2'b01, 2);
    rflags("second stop", 8'h40);
    wr(`ASU_FLAG_OFS, 8'hBF);
    repeat (200) @(posedge clk);
    wr(`ASU_FLAG_OFS, 8'h84);
    far_u.send({1'b0, 8'h4D}, 8, 2'b11, 2);
    far_u.send({1'b0, 8'h7E}, 8, 2'b11, 2);
    rflags("overrun", 8'h60);
    chk("ovr irq", 9'h001, 9'(rxErrIrq));
    wr(`ASU_CTRL_OFS, 8'h00);
    rflags("rx off keeps", 8'h60);
    rd(`ASU_RXD_OFS, rv);
    chk("kept data", 9'h04D, 9'(rv));
    // Seven data bits with the address flag after them
    cfg(8'h44, 8'h50);
    wr(`ASU_FLAG_OFS, 8'h84);
    far_u.send({2'b01, 7'h35}, 8, 2'b11, 1);
    rflags("rx 7 bit", 8'h40);
    chk("rx flag bit", 9'h001, 9'(rv[1]));
    rd(`ASU_RXD_OFS, rv);
    chk("rx 7 data", 9'h035, 9'(rv));
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_tx();
    t_b2b();
    t_abort();
    t_rx();
    t_err();
    t_stops();
    stop_test();
  end
endmodule
